/* File: strap_led_pkg.sv */
// constants for the shared address-strap / status-led pins
// assumes a single 250 MHz system clock and an asynchronous active-high reset
//
// Function
// - The collision pin gives address bit 1 at reset and then shows collision status.
// - The link pin gives address bit 2 at reset and then shows whether a valid link exists.
// - The transmit pin gives address bit 3 at reset and then shows transmit activity.
// - The receive pin gives address bit 4 at reset and then shows receive activity.
// - During power-on or hardware reset every shared pin is an input that sets the address.
// - A low level on a shared pin gives a zero address bit and a high level gives a one.
// - After reset ends every shared pin turns into an output driving its indication.
// - A detected collision holds the collision indication on for about 70 ms.
// - The activity pin gives address bit 0 at reset and then shows transmit or receive activity.
// - The asserted output level is the inverse of the level sampled during reset.
// - A software reset neither resamples the pins nor takes them out of output mode.
package strap_led_pkg;
    localparam int unsigned PIN_COUNT = 5;
    localparam int unsigned BIT_ACTIVITY = 0;
    localparam int unsigned BIT_COLLISION = 1;
    localparam int unsigned BIT_LINK = 2;
    localparam int unsigned BIT_TRANSMIT = 3;
    localparam int unsigned BIT_RECEIVE = 4;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned COLLISION_HOLD_MS = 70;
    // longest time: rounds down
    localparam int unsigned COLLISION_HOLD_CYCLES =
        32'((COLLISION_HOLD_MS * 64'd1000000000) / CLK_PERIOD_PS);
    // settle cycles between reset release and the strap capture
    localparam int unsigned STRAP_SETTLE_CYCLES = 3;
    localparam logic [4:0] ADDR_RESET = 5'h00;
endpackage

/* File: collision_stretch.sv */
// pulse stretcher holding the collision indication for a fixed time
// assumes collision_in is synchronous to clk_sys_in
`timescale 1ns/1ps
`default_nettype none
module collision_stretch #(
    parameter int unsigned HOLD_CYCLES = strap_led_pkg::COLLISION_HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // event and stretched level
    input wire logic collision_in,
    output logic stretched_out
);
    localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(HOLD_CYCLES);
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;

    // every new collision restarts the full hold
    always_comb begin
        count_next = count_reg;
        if (collision_in) begin
            count_next = LOAD;
        end else if (count_reg != '0) begin
            count_next = count_reg - CW'(1);
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign stretched_out = (count_reg != '0);

    a_hold_after_event: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        collision_in |=> (count_reg == LOAD) && stretched_out)
        else $error("collision hold not loaded");
    a_hold_ends: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        (count_reg == CW'(1)) && !collision_in |=> !stretched_out)
        else $error("collision hold did not end");
endmodule
`default_nettype wire

/* File: strap_led_pins.sv */
// shared pins: address straps during reset, status led drivers afterwards
// assumes rst_in is the power-on / hardware reset; soft reset arrives separately
`timescale 1ns/1ps
`default_nettype none
module strap_led_pins #(
    parameter int unsigned HOLD_CYCLES = strap_led_pkg::COLLISION_HOLD_CYCLES
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic soft_reset_in,
    // status from the link logic
    input wire logic collision_in,
    input wire logic link_valid_in,
    input wire logic tx_active_in,
    input wire logic rx_active_in,
    // shared pins, bit order follows the address bits
    input wire logic [4:0] pin_in,
    output logic [4:0] pin_out,
    output logic [4:0] pin_oe_out,
    // captured management address
    output logic [4:0] phy_addr_out,
    output logic addr_valid_out
);
    typedef enum logic [1:0] {ST_SAMPLE, ST_DRIVE} phase_t;

    phase_t phase_reg;
    phase_t phase_next;
    logic [1:0] settle_reg;
    logic [1:0] settle_next;
    logic [4:0] addr_reg;
    logic [4:0] addr_next;
    logic [4:0] pin_reg;
    logic [4:0] pin_next;
    logic [4:0] oe_reg;
    logic [4:0] oe_next;
    // three-stage synchroniser on the pad inputs
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync3_reg;
    logic [4:0] stable_reg;
    logic [4:0] stable_next;
    logic collision_held;
    logic [4:0] status;

    collision_stretch #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_collision (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .collision_in(collision_in),
        .stretched_out(collision_held)
    );

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            sync3_reg <= 5'h00;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // a bit changes only once stages two and three agree
    always_comb begin
        stable_next = stable_reg;
        for (int i = 0; i < 5; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
                stable_next[i] = sync3_reg[i];
            end
        end
    end

    // raw, active-high indications in address-bit order
    always_comb begin
        status = 5'h00;
        status[strap_led_pkg::BIT_ACTIVITY] = tx_active_in | rx_active_in;
        status[strap_led_pkg::BIT_COLLISION] = collision_held;
        status[strap_led_pkg::BIT_LINK] = link_valid_in;
        status[strap_led_pkg::BIT_TRANSMIT] = tx_active_in;
        status[strap_led_pkg::BIT_RECEIVE] = rx_active_in;
    end

    // soft reset is deliberately ignored here: pins stay outputs
    always_comb begin
        phase_next = phase_reg;
        settle_next = settle_reg;
        addr_next = addr_reg;
        pin_next = 5'h00;
        oe_next = 5'h00;
        unique case (phase_reg)
            ST_SAMPLE: begin
                // wait for the synchroniser to fill with real pad levels
                if (settle_reg == 2'(strap_led_pkg::STRAP_SETTLE_CYCLES)) begin
                    // stable_reg lags the filter by one edge; take this edge's value
                    addr_next = stable_next;
                    phase_next = ST_DRIVE;
                end else begin
                    settle_next = settle_reg + 2'h1;
                end
            end
            ST_DRIVE: begin
                oe_next = 5'h1F;
                // idle level matches the strap resistor, so the led stays dark
                pin_next = status ^ addr_reg;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            phase_reg <= ST_SAMPLE;
            settle_reg <= 2'h0;
            addr_reg <= strap_led_pkg::ADDR_RESET;
            pin_reg <= 5'h00;
            oe_reg <= 5'h00;
            stable_reg <= 5'h00;
        end else begin
            phase_reg <= phase_next;
            settle_reg <= settle_next;
            addr_reg <= addr_next;
            pin_reg <= pin_next;
            oe_reg <= oe_next;
            stable_reg <= stable_next;
        end
    end

    assign pin_out = pin_reg;
    assign pin_oe_out = oe_reg;
    assign phy_addr_out = addr_reg;
    assign addr_valid_out = (phase_reg == ST_DRIVE);

    sequence s_captured;
        phase_reg == ST_SAMPLE ##1 phase_reg == ST_DRIVE;
    endsequence

    sequence s_driving;
        phase_reg == ST_DRIVE ##1 phase_reg == ST_DRIVE;
    endsequence

    // collision sampled, then the stretched level reaches the pin register
    sequence s_collision_seen;
        (phase_reg == ST_DRIVE && collision_in) ##1 (phase_reg == ST_DRIVE);
    endsequence

    a_inputs_during_sample: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_SAMPLE |=> pin_oe_out == 5'h00)
        else $error("shared pin driven while sampling");

    a_quiet_during_sample: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_SAMPLE |=> pin_out == 5'h00)
        else $error("pin level set while sampling");

    // pad level at the first edge after release; straps must hold still
    a_capture_value: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_captured |-> phy_addr_out == $past(pin_in, 4))
        else $error("address not taken from pins");

    a_drive_after: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_captured |=> pin_oe_out == 5'h1F)
        else $error("pins not outputs after reset");

    a_outputs_kept: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_driving |-> pin_oe_out == 5'h1F)
        else $error("pins left output mode");

    a_addr_held: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_driving |-> $stable(phy_addr_out))
        else $error("address changed after capture");

    a_soft_reset_kept: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE && soft_reset_in |=> pin_oe_out == 5'h1F)
        else $error("soft reset disturbed pins");

    a_sample_bound: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_SAMPLE |-> ##[1:5] phase_reg == ST_DRIVE)
        else $error("strap capture late");

    // each led pin: asserted level is the inverse of its strap
    a_link_level: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE |=> pin_out[2] == ($past(link_valid_in) ^ phy_addr_out[2]))
        else $error("link pin level wrong");

    a_transmit_level: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE |=> pin_out[3] == ($past(tx_active_in) ^ phy_addr_out[3]))
        else $error("transmit pin level wrong");

    a_receive_level: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE |=> pin_out[4] == ($past(rx_active_in) ^ phy_addr_out[4]))
        else $error("receive pin level wrong");

    a_activity_level: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE |=>
        pin_out[0] == ($past(tx_active_in || rx_active_in) ^ phy_addr_out[0]))
        else $error("activity pin level wrong");

    a_collision_level: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE |=>
        pin_out[1] == ($past(collision_held) ^ phy_addr_out[1]))
        else $error("collision pin level wrong");

    a_collision_pin: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        s_collision_seen |=> pin_out[1] == ~phy_addr_out[1])
        else $error("collision pin not asserted");

    a_activity_pin: assert property (
        @(posedge clk_sys_in) disable iff (rst_in)
        phase_reg == ST_DRIVE && !tx_active_in && !rx_active_in |=>
        pin_out[0] == phy_addr_out[0] && pin_out[3] == phy_addr_out[3]
        && pin_out[4] == phy_addr_out[4])
        else $error("activity pins not idle");
endmodule
`default_nettype wire

/* File: board_leds.sv */
// board model: one pull resistor per shared pin with an led in series
// assumes oe high means the device drives the pad
`timescale 1ns/1ps
`default_nettype none
module board_leds (
    // strap choice on the board, 1 = pulled up
    input wire logic [4:0] pull_up_in,
    // device pad side
    input wire logic [4:0] drive_in,
    input wire logic [4:0] oe_in,
    // resolved pad level and led state
    output logic [4:0] pad_out,
    output logic [4:0] led_lit_out
);
    // a released pad settles to its resistor, never floats
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            pad_out[i] = oe_in[i] ? drive_in[i] : pull_up_in[i];
            led_lit_out[i] = oe_in[i] && (drive_in[i] != pull_up_in[i]);
        end
    end
endmodule
`default_nettype wire

/* File: tb.sv */
// testbench for the shared strap / led pins
// assumes the board model resolves pad levels from the pulls
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int unsigned HOLD = 20;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic soft_reset_in = 1'b0;
    logic collision_in = 1'b0;
    logic [2:0] status = 3'h0;
    logic [4:0] pull_up = 5'h16;
    logic [4:0] pad, led_lit, pin_out, pin_oe_out, phy_addr_out;
    logic addr_valid_out;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;
    always #2 clk_sys_in = ~clk_sys_in;
    strap_led_pins #(.HOLD_CYCLES(HOLD)) i_strap_led_pins (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .soft_reset_in(soft_reset_in),
        .collision_in(collision_in), .link_valid_in(status[0]),
        .tx_active_in(status[1]), .rx_active_in(status[2]),
        .pin_in(pad), .pin_out(pin_out), .pin_oe_out(pin_oe_out),
        .phy_addr_out(phy_addr_out), .addr_valid_out(addr_valid_out));
    board_leds i_board_leds (.pull_up_in(pull_up), .drive_in(pin_out),
        .oe_in(pin_oe_out), .pad_out(pad), .led_lit_out(led_lit));
    task automatic check(input logic [4:0] exp, input logic [4:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic check_flag(input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic complete_run();
        if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic test_strap(input logic [4:0] pulls);
        int n;
        n = 0;
        ticks(1);
        pull_up = pulls;
        rst_in = 1'b1;
        ticks(10);
        check(5'h00, pin_oe_out);
        check(5'h00, pin_out);
        check(pulls, pad);
        check(strap_led_pkg::ADDR_RESET, phy_addr_out);
        check_flag(1'b0, addr_valid_out);
        rst_in = 1'b0;
        while (addr_valid_out !== 1'b1 && n < 20) begin
            ticks(1);
            n++;
        end
        check(5'(strap_led_pkg::STRAP_SETTLE_CYCLES + 1), 5'(n));
        check_flag(1'b1, addr_valid_out);
        ticks(2);
        check(pulls, phy_addr_out);
        check(5'h1F, pin_oe_out);
        check(pulls, pad);
        check(5'h00, led_lit);
    endtask
    task automatic test_status();
        logic [4:0] m;
        for (int i = 1; i < 8; i++) begin
            status = i[2:0];
            m = {status[2], status[1], status[0], 1'b0, status[2] | status[1]};
            ticks(2);
            check(pull_up ^ m, pad);
            check(m, led_lit);
        end
        status = 3'h0;
        ticks(2);
        check(pull_up, pad);
    endtask
    task automatic pulse();
        collision_in = 1'b1;
        ticks(1);
        collision_in = 1'b0;
    endtask
    task automatic test_collision();
        pulse();
        ticks(1);
        check(pull_up ^ 5'h02, pad);
        ticks(HOLD - 2);
        check(pull_up ^ 5'h02, pad);
        ticks(3);
        check(pull_up, pad);
        pulse();
        ticks(HOLD / 2);
        pulse();
        ticks(HOLD - 2);
        check(5'h02, led_lit);
        ticks(5);
        check(5'h00, led_lit);
    endtask
    task automatic test_soft_reset();
        logic [4:0] a;
        a = phy_addr_out;
        soft_reset_in = 1'b1;
        pull_up = ~a;
        ticks(5);
        check(5'h1F, pin_oe_out);
        check(a, phy_addr_out);
        check(a, pad);
        soft_reset_in = 1'b0;
        pull_up = a;
        ticks(2);
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        test_strap(5'h16);
        test_status();
        test_collision();
        test_soft_reset();
        test_strap(5'h09);
        test_status();
        complete_run();
    end
endmodule
`default_nettype wire
